// ===== common/asp2_pkg.sv
// Constants for the second asynchronous serial port: register map, field positions, rate scaling.
// Assumes an APB master with 32-bit data; each register sits in the low byte of one aligned word.
package asp2_pkg;
  // Register indices; the APB byte address is four times the index.
  localparam logic [15:0] RX_CONTROL_IDX   = 16'hfee8;
  localparam logic [15:0] TX_CONTROL_IDX   = 16'hfee9;
  localparam logic [15:0] BAUD_RELOAD_IDX  = 16'hfeea;
  localparam logic [15:0] TX_HOLDING_IDX   = 16'hfeeb;
  localparam logic [15:0] RX_HOLDING_IDX   = 16'hfeec;
  localparam logic [17:0] RX_CONTROL_ADDR  = {RX_CONTROL_IDX, 2'b00};
  localparam logic [17:0] TX_CONTROL_ADDR  = {TX_CONTROL_IDX, 2'b00};
  localparam logic [17:0] BAUD_RELOAD_ADDR = {BAUD_RELOAD_IDX, 2'b00};
  localparam logic [17:0] TX_HOLDING_ADDR  = {TX_HOLDING_IDX, 2'b00};
  localparam logic [17:0] RX_HOLDING_ADDR  = {RX_HOLDING_IDX, 2'b00};
  // Reset values.
  localparam logic [7:0]  RX_CONTROL_RST   = 8'h00;
  localparam logic [7:0]  TX_CONTROL_RST   = 8'h00;
  localparam logic [7:0]  BAUD_RELOAD_RST  = 8'h00;
  localparam logic [7:0]  TX_HOLDING_RST   = 8'h00;
  localparam logic [7:0]  RX_HOLDING_RST   = 8'h00;
  // rx_control fields.
  localparam int RC_RATE    = 7;
  localparam int RC_START   = 6;
  localparam int RC_RUN     = 5;
  localparam int RC_STOPERR = 4;
  localparam int RC_GENERAL = 3;
  localparam int RC_NINTH   = 2;
  localparam int RC_END     = 1;
  localparam int RC_IE      = 0;
  // tx_control fields.
  localparam int TC_RUN     = 7;
  localparam int TC_NINE    = 6;
  localparam int TC_OE      = 5;
  localparam int TC_TYPE    = 4;
  localparam int TC_SEVEN   = 3;
  localparam int TC_NINTH   = 2;
  localparam int TC_DONE    = 1;
  localparam int TC_IE      = 0;
  // Data lengths in bits.
  localparam logic [3:0]  LEN7 = 4'h7;
  localparam logic [3:0]  LEN8 = 4'h8;
  localparam logic [3:0]  LEN9 = 4'h9;
  // Bit period is (n+1) shifted by these, in thirds of a cycle: x8 fine, x32 coarse.
  localparam logic [2:0]  FINE_SHIFT   = 3'h3;
  localparam logic [2:0]  COARSE_SHIFT = 3'h5;
  // Thirds added per cycle: 3 gives bit ticks, 6 gives half-bit ticks.
  localparam logic [13:0] TX_STEP = 14'h0003;
  localparam logic [13:0] RX_STEP = 14'h0006;
endpackage

// ===== src/asp2_uart.sv
// Second asynchronous serial port: APB register file, transmitter and receiver.
// Assumes an APB master on mclk, rxd straight from a pin, port_dir_tx from port logic on mclk.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module asp2_uart (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        port_dir_tx,
  output logic             txd_out,
  output logic             txd_oe,
  output logic             tx_irq,
  output logic             rx_irq
);
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_LOAD  = 2'b01,
    TX_SHIFT = 2'b11,
    TX_STOP2 = 2'b10
  } asp2_tx_state_t;
  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_BUSY = 1'b1
  } asp2_rx_state_t;

  // Bit period in thirds of a cycle, shared by both paths.
  function automatic logic [13:0] baud_period(input logic [7:0] n, input logic coarse);
    baud_period = ({6'h00, n} + 14'h0001) << (coarse ? asp2_pkg::COARSE_SHIFT : asp2_pkg::FINE_SHIFT);
  endfunction

  // Character length from the two select bits.
  function automatic logic [3:0] data_len(input logic nine, input logic seven);
    data_len = nine ? asp2_pkg::LEN9 : (seven ? asp2_pkg::LEN7 : asp2_pkg::LEN8);
  endfunction

  logic [7:0]     rx_ctl_reg,   rxc_next;
  logic [7:0]     tx_ctl_reg,   txc_next;
  logic [7:0]     baud_reg,     baud_next;
  logic [7:0]     txh_reg,      txh_next;
  logic [7:0]     rxh_reg,      rxh_next;
  asp2_tx_state_t tx_state_reg, tx_state_next;
  logic [10:0]    tx_sh_reg,    tx_sh_next;
  logic [3:0]     tx_cnt_reg,   tx_cnt_next;
  logic [13:0]    tx_acc_reg,   tx_acc_next;
  logic [13:0]    tx_per_reg,   tx_per_next;
  logic [3:0]     tx_len_reg,   tx_len_next;
  asp2_rx_state_t rx_state_reg, rx_state_next;
  logic [10:0]    rx_sh_reg,    rx_sh_next;
  logic [3:0]     rx_idx_reg,   rx_idx_next;
  logic           rx_half_reg,  rx_half_next;
  logic           rx_last_reg,  rx_last_next;
  logic [13:0]    rx_acc_reg,   rx_acc_next;
  logic [13:0]    rx_per_reg,   rx_per_next;
  logic [3:0]     rx_len_reg,   rx_len_next;
  logic [31:0]    prdata_reg,   prdata_next;
  logic           pready_reg,   pready_next;
  logic           pslverr_reg,  pslverr_next;
  logic           txd_out_reg,  txd_out_next;
  logic           txd_oe_reg,   txd_oe_next;
  logic           tx_irq_reg,   tx_irq_next;
  logic           rx_irq_reg,   rx_irq_next;
  logic           rx_sync1_reg;
  logic           rx_sync2_reg;
  logic           rx_prev_reg;
  logic           wr_en;
  logic           setup;
  logic           tx_tick;
  logic           rx_tick;
  logic           rx_fall;
  logic           rx_done;
  logic           tx_line;
  logic           tx_drive;
  logic [8:0]     tx_word;
  logic [7:0]     rd_val;
  logic           rd_hit;

  // Writes take effect only at the access edge where pready is high.
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & pready_reg;
  assign tx_tick = (tx_acc_reg + asp2_pkg::TX_STEP) >= tx_per_reg;
  assign rx_tick = (rx_acc_reg + asp2_pkg::RX_STEP) >= rx_per_reg;
  // The edge detector reads only the second synchroniser stage and its delayed copy.
  assign rx_fall = rx_prev_reg & ~rx_sync2_reg;
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd_out = txd_out_reg;
  assign txd_oe  = txd_oe_reg;
  assign tx_irq  = tx_irq_reg;
  assign rx_irq  = rx_irq_reg;

  // Read decode; the shifters have no address and stay hidden.
  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      asp2_pkg::RX_CONTROL_ADDR:  rd_val = rx_ctl_reg;
      asp2_pkg::TX_CONTROL_ADDR:  rd_val = tx_ctl_reg;
      asp2_pkg::BAUD_RELOAD_ADDR: rd_val = baud_reg;
      asp2_pkg::TX_HOLDING_ADDR:  rd_val = txh_reg;
      asp2_pkg::RX_HOLDING_ADDR:  rd_val = rxh_reg;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Next state of registers, both serial paths and pins.
  always_comb begin
    rxc_next      = rx_ctl_reg;
    txc_next      = tx_ctl_reg;
    baud_next     = baud_reg;
    txh_next      = txh_reg;
    rxh_next      = rxh_reg;
    tx_state_next = tx_state_reg;
    tx_sh_next    = tx_sh_reg;
    tx_cnt_next   = tx_cnt_reg;
    tx_per_next   = tx_per_reg;
    tx_len_next   = tx_len_reg;
    tx_acc_next   = tx_tick ? tx_acc_reg + asp2_pkg::TX_STEP - tx_per_reg : tx_acc_reg + asp2_pkg::TX_STEP;
    rx_state_next = rx_state_reg;
    rx_sh_next    = rx_sh_reg;
    rx_idx_next   = rx_idx_reg;
    rx_half_next  = rx_half_reg;
    rx_last_next  = rx_last_reg;
    rx_per_next   = rx_per_reg;
    rx_len_next   = rx_len_reg;
    rx_acc_next   = rx_tick ? rx_acc_reg + asp2_pkg::RX_STEP - rx_per_reg : rx_acc_reg + asp2_pkg::RX_STEP;
    rx_done       = 1'b0;
    pready_next   = setup;
    pslverr_next  = setup & ~rd_hit;
    prdata_next   = setup ? {24'h00_0000, rd_val} : 32'h0000_0000;
    // register writes
    // Writes land first so that hardware events below win over them.
    if (wr_en) begin
      case (paddr)
        asp2_pkg::RX_CONTROL_ADDR:  rxc_next  = pwdata[7:0];
        asp2_pkg::TX_CONTROL_ADDR:  txc_next  = pwdata[7:0];
        asp2_pkg::BAUD_RELOAD_ADDR: baud_next = pwdata[7:0];
        asp2_pkg::TX_HOLDING_ADDR:  txh_next  = pwdata[7:0];
        asp2_pkg::RX_HOLDING_ADDR:  rxh_next  = pwdata[7:0];
        default: ;
      endcase
    end
    // transmit word
    // Unused upper positions fill with ones so they read as stop level.
    case (tx_len_reg)
      asp2_pkg::LEN9: tx_word = {tx_ctl_reg[asp2_pkg::TC_NINTH], txh_reg};
      asp2_pkg::LEN7: tx_word = {2'b11, txh_reg[6:0]};
      default:        tx_word = {1'b1, txh_reg};
    endcase
    case (tx_state_reg)
      TX_IDLE: begin
        tx_acc_next = 14'h0000;
        if (txc_next[asp2_pkg::TC_RUN]) begin
          tx_state_next = TX_LOAD;
          tx_per_next = baud_period(baud_next, rxc_next[asp2_pkg::RC_RATE]);
          tx_len_next = data_len(txc_next[asp2_pkg::TC_NINE], txc_next[asp2_pkg::TC_SEVEN]);
        end
      end
      TX_LOAD: begin
        tx_acc_next   = 14'h0000;
        tx_sh_next    = {1'b1, tx_word, 1'b0};
        tx_cnt_next   = tx_len_reg + 4'h2;
        txc_next[asp2_pkg::TC_DONE] = 1'b1;
        tx_state_next = TX_SHIFT;
      end
      TX_SHIFT: begin
        if (tx_tick) begin
          tx_sh_next  = {1'b1, tx_sh_reg[10:1]};
          tx_cnt_next = tx_cnt_reg - 4'h1;
          if (tx_cnt_reg == 4'h1) begin
            // continuous second stop
            // A cleared done flag means software queued the next character.
            if (!tx_ctl_reg[asp2_pkg::TC_DONE]) begin
              tx_state_next = TX_STOP2;
            end else begin
              txc_next[asp2_pkg::TC_RUN] = 1'b0;
              tx_state_next = TX_IDLE;
            end
          end
        end
      end
      TX_STOP2: begin
        if (tx_tick) begin
          tx_state_next = TX_LOAD;
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
    // Clearing tx_run mid-character abandons it and returns the line to idle.
    if (tx_state_reg != TX_IDLE && !txc_next[asp2_pkg::TC_RUN]) begin
      tx_state_next = TX_IDLE;
      tx_sh_next    = 11'h7ff;
    end
    case (rx_state_reg)
      RX_IDLE: begin
        rx_acc_next = 14'h0000;
        if (rxc_next[asp2_pkg::RC_START] && rx_fall) begin
          rx_state_next = RX_BUSY;
          rxc_next[asp2_pkg::RC_RUN] = 1'b1;
          rx_per_next  = baud_period(baud_next, rxc_next[asp2_pkg::RC_RATE]);
          rx_len_next  = data_len(txc_next[asp2_pkg::TC_NINE], txc_next[asp2_pkg::TC_SEVEN]);
          rx_idx_next  = 4'h0;
          rx_half_next = 1'b0;
        end
      end
      RX_BUSY: begin
        if (!rxc_next[asp2_pkg::RC_RUN]) begin
          rx_done = 1'b1;
        end else if (rx_tick) begin
          rx_half_next = ~rx_half_reg;
          // mid-bit sampling
          // Half-bit ticks alternate between bit middles and bit boundaries.
          if (!rx_half_reg) begin
            rx_sh_next[rx_idx_reg] = rx_sync2_reg;
            rx_last_next = rx_sync2_reg;
            rx_idx_next  = rx_idx_reg + 4'h1;
            if (rx_idx_reg == rx_len_reg + 4'h1) begin
              rx_done = 1'b1;
            end
          end
        end
      end
      default: rx_state_next = RX_IDLE;
    endcase
    if (rx_done) begin
      rx_state_next = RX_IDLE;
      rxc_next[asp2_pkg::RC_RUN] = 1'b0;
      rxc_next[asp2_pkg::RC_END] = 1'b1;
      if (!rx_last_next) begin
        rxc_next[asp2_pkg::RC_STOPERR] = 1'b1;
      end
      if (rx_len_reg == asp2_pkg::LEN9) begin
        rxc_next[asp2_pkg::RC_NINTH] = rx_sh_next[9];
      end
      rxh_next = (rx_len_reg == asp2_pkg::LEN7) ? {1'b0, rx_sh_next[7:1]} : rx_sh_next[8:1];
    end
    // output suppression
    // Open drain drives only the low level; CMOS drives both.
    tx_line      = (tx_state_reg == TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
    tx_drive     = tx_ctl_reg[asp2_pkg::TC_OE] & ~port_dir_tx;
    txd_out_next = tx_ctl_reg[asp2_pkg::TC_TYPE] & tx_line;
    txd_oe_next  = tx_drive & (tx_ctl_reg[asp2_pkg::TC_TYPE] | ~tx_line);
    tx_irq_next  = tx_ctl_reg[asp2_pkg::TC_IE] & tx_ctl_reg[asp2_pkg::TC_DONE];
    rx_irq_next  = rx_ctl_reg[asp2_pkg::RC_IE] & rx_ctl_reg[asp2_pkg::RC_END];
  end

  // Registers of the whole block except the receive-pin synchroniser.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctl_reg   <= asp2_pkg::RX_CONTROL_RST;
      tx_ctl_reg   <= asp2_pkg::TX_CONTROL_RST;
      baud_reg     <= asp2_pkg::BAUD_RELOAD_RST;
      txh_reg      <= asp2_pkg::TX_HOLDING_RST;
      rxh_reg      <= asp2_pkg::RX_HOLDING_RST;
      tx_state_reg <= TX_IDLE;
      tx_sh_reg    <= 11'h7ff;
      tx_cnt_reg   <= 4'h0;
      tx_acc_reg   <= 14'h0000;
      tx_per_reg   <= 14'h0000;
      tx_len_reg   <= 4'h8;
      rx_state_reg <= RX_IDLE;
      rx_sh_reg    <= 11'h000;
      rx_idx_reg   <= 4'h0;
      rx_half_reg  <= 1'b0;
      rx_last_reg  <= 1'b1;
      rx_acc_reg   <= 14'h0000;
      rx_per_reg   <= 14'h0000;
      rx_len_reg   <= 4'h8;
      prdata_reg   <= 32'h0000_0000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      txd_out_reg  <= 1'b0;
      txd_oe_reg   <= 1'b0;
      tx_irq_reg   <= 1'b0;
      rx_irq_reg   <= 1'b0;
    end else begin
      rx_ctl_reg   <= rxc_next;
      tx_ctl_reg   <= txc_next;
      baud_reg     <= baud_next;
      txh_reg      <= txh_next;
      rxh_reg      <= rxh_next;
      tx_state_reg <= tx_state_next;
      tx_sh_reg    <= tx_sh_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_acc_reg   <= tx_acc_next;
      tx_per_reg   <= tx_per_next;
      tx_len_reg   <= tx_len_next;
      rx_state_reg <= rx_state_next;
      rx_sh_reg    <= rx_sh_next;
      rx_idx_reg   <= rx_idx_next;
      rx_half_reg  <= rx_half_next;
      rx_last_reg  <= rx_last_next;
      rx_acc_reg   <= rx_acc_next;
      rx_per_reg   <= rx_per_next;
      rx_len_reg   <= rx_len_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      txd_out_reg  <= txd_out_next;
      txd_oe_reg   <= txd_oe_next;
      tx_irq_reg   <= tx_irq_next;
      rx_irq_reg   <= rx_irq_next;
    end
  end

  // Two-stage synchroniser for the receive pin, then a delayed copy for edges.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync1_reg <= 1'b1;
      rx_sync2_reg <= 1'b1;
      rx_prev_reg  <= 1'b1;
    end else begin
      rx_sync1_reg <= rxd;
      rx_sync2_reg <= rx_sync1_reg;
      rx_prev_reg  <= rx_sync2_reg;
    end
  end

  // Checks on the serial paths.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_load_sets_done: assert property (tx_state_reg == TX_LOAD
    |=> tx_ctl_reg[asp2_pkg::TC_DONE] && !tx_sh_reg[0])
    else $error("Transmit load did not set done or start bit.");
  a_two_stop_bits: assert property (tx_state_reg == TX_SHIFT && tx_tick && tx_cnt_reg == 4'h1
    && !tx_ctl_reg[asp2_pkg::TC_DONE] && tx_ctl_reg[asp2_pkg::TC_RUN] && !wr_en |=> tx_state_reg == TX_STOP2)
    else $error("Continuous character lacks second stop bit.");
  a_cont_gap_one: assert property (tx_state_reg == TX_STOP2 && tx_tick && !wr_en
    |=> tx_state_reg == TX_LOAD && tx_ctl_reg[asp2_pkg::TC_RUN] ##1 tx_state_reg == TX_SHIFT)
    else $error("Continuous gap is not one cycle.");
  a_tx_rate_held: assert property (tx_state_reg != TX_IDLE && tx_state_next != TX_IDLE
    |=> $stable(tx_per_reg) && $stable(tx_len_reg))
    else $error("Transmit rate or length changed mid-sequence.");
  a_rx_start_edge: assert property (rx_state_reg == RX_IDLE && rx_ctl_reg[asp2_pkg::RC_START] && rx_fall && !wr_en
    |=> rx_state_reg == RX_BUSY && rx_ctl_reg[asp2_pkg::RC_RUN])
    else $error("Start edge did not begin reception.");
  a_rx_end_flag: assert property (rx_done |=> rx_ctl_reg[asp2_pkg::RC_END] && !rx_ctl_reg[asp2_pkg::RC_RUN]
    && rx_state_reg == RX_IDLE)
    else $error("Reception end not flagged.");
  a_tx_irq_req: assert property (tx_ctl_reg[asp2_pkg::TC_IE] && tx_ctl_reg[asp2_pkg::TC_DONE] |=> tx_irq)
    else $error("Transmit interrupt missing.");
  a_rx_irq_req: assert property (rx_ctl_reg[asp2_pkg::RC_IE] && rx_ctl_reg[asp2_pkg::RC_END] |=> rx_irq)
    else $error("Receive interrupt missing.");
  a_tx_mute_pin: assert property (port_dir_tx |=> !txd_oe)
    else $error("Transmit pin driven while direction bit set.");
  a_baud_idle_hold: assert property (tx_state_reg == TX_IDLE ##1 tx_state_reg == TX_LOAD
    |=> tx_acc_reg == 14'h0000)
    else $error("Baud counter not reloaded at start.");

  c_cont_tx: cover property (tx_state_reg == TX_STOP2 ##[1:1000] tx_state_reg == TX_LOAD);
  c_rx_char: cover property (rx_done && rx_state_reg == RX_BUSY && rx_ctl_reg[asp2_pkg::RC_RUN]);
  c_duplex: cover property (tx_state_reg == TX_SHIFT && rx_state_reg == RX_BUSY);
endmodule // asp2_uart

// ===== test/asp2_peer.sv
// Remote serial peer: decodes frames seen on the transmit pin and sends frames on the receive pin.
// Assumes a pulled-up line; the bench keeps bit_cyc and len_bits matched to each frame.
`timescale 1ns/1ps
module asp2_peer (
  input  wire logic mclk,
  input  wire logic txd_out,
  input  wire logic txd_oe,
  output logic      rxd
);
  int         bit_cyc  = 8;
  int         len_bits = 8;
  int         cyc      = 0;
  logic [9:0] got_q[$];
  int         start_t[$];
  wire        line = !(txd_oe && !txd_out);

  initial rxd = 1'b1;
  // Free cycle count, used to time the gap between frame starts.
  always @(posedge mclk) cyc <= cyc + 1;

  // LSB first decode
  // Sampling at bit middles keeps a one-cycle skew of the start edge harmless.
  initial begin : rx_side
    logic [9:0] v;
    forever begin
      @(posedge mclk);
      if (line === 1'b0) begin
        start_t.push_back(cyc);
        v = 10'h000;
        repeat (bit_cyc / 2) @(posedge mclk);
        for (int i = 0; i < len_bits + 1; i++) begin
          repeat (bit_cyc) @(posedge mclk);
          v = {line, v[9:1]};
        end
        got_q.push_back(v >> (9 - len_bits));
      end
    end
  end

  // LSB first frame
  // The line returns to the pulled-up idle level as soon as the frame ends.
  task automatic send_char(input logic [8:0] d, input int len, input int bc, input logic stop);
    logic [10:0] f;
    f = {1'b0, d, 1'b0};
    f[len+1] = stop;
    for (int i = 0; i < len + 2; i++) begin
      rxd <= f[i];
      repeat (bc) @(posedge mclk);
    end
    rxd <= 1'b1;
  endtask
endmodule // asp2_peer

// ===== test/tb.sv
// Self-checking bench for the second serial port: APB master, expected values, serial peer.
// Assumes the design answers APB through pready and the peer owns the receive pin.
`timescale 1ns/1ps
module tb;
  logic        mclk, rst_n, psel, penable, pwrite, port_dir_tx, oe_bad, pd_q;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rxd, txd_out, txd_oe, tx_irq, rx_irq, err;
  logic [8:0]  d;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          lens[3]     = '{7, 8, 9};
  logic [17:0] addrs[5]    = '{asp2_pkg::RX_CONTROL_ADDR, asp2_pkg::TX_CONTROL_ADDR,
    asp2_pkg::BAUD_RELOAD_ADDR, asp2_pkg::TX_HOLDING_ADDR, asp2_pkg::RX_HOLDING_ADDR};

  asp2_uart u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .port_dir_tx(port_dir_tx), .txd_out(txd_out), .txd_oe(txd_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
  asp2_peer u_peer (.mclk(mclk), .txd_out(txd_out), .txd_oe(txd_oe), .rxd(rxd));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // The pin may drive for one cycle after the direction bit rises, so the check starts a cycle later.
  always @(posedge mclk) begin
    pd_q <= port_dir_tx;
    if (pd_q && port_dir_tx && txd_oe !== 1'b0) oe_bad <= 1'b1;
  end
  // A hang is cut short well after the longest expected run.
  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic [17:0] a, input logic w, input logic [7:0] v);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, v};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_bit(input logic [17:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(a, 1'b0, 8'h00);
      n++;
    end while (rd[b] !== v && n < 3000);
    chk("polled bit", {31'h0000_0000, rd[b]}, {31'h0000_0000, v});
  endtask
  task automatic get_frame(input int len, input logic [8:0] v);
    int n;
    logic [31:0] e;
    n = 0;
    e = (32'(v) & ((32'h0000_0001 << len) - 1)) | (32'h0000_0001 << len);
    while (u_peer.got_q.size() == 0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    chk("frame", u_peer.got_q.size() > 0 ? 32'(u_peer.got_q.pop_front()) : 32'hxxxx_xxxx, e);
  endtask
  task automatic tx_one(input int len, input logic [8:0] v);
    logic [7:0] c;
    int n;
    c = 8'hb1 | (len == 9 ? 8'h40 : 8'h00) | (len == 7 ? 8'h08 : 8'h00) | (v[8] ? 8'h04 : 8'h00);
    n = 0;
    u_peer.len_bits = len;
    apb(asp2_pkg::TX_HOLDING_ADDR, 1'b1, v[7:0]);
    apb(asp2_pkg::TX_CONTROL_ADDR, 1'b1, c);
    while (tx_irq !== 1'b1 && n < 4) begin
      @(posedge mclk);
      n++;
    end
    chk("tx_irq at start", {31'h0000_0000, tx_irq}, 32'h0000_0001);
    wait_bit(asp2_pkg::TX_CONTROL_ADDR, asp2_pkg::TC_RUN, 1'b0);
    get_frame(len, v);
    apb(asp2_pkg::TX_CONTROL_ADDR, 1'b1, 8'h30);
  endtask
  task automatic rx_check(input int len, input logic [8:0] v, input logic stop);
    int n;
    n = 0;
    while (rx_irq !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk("rx_irq at end", {31'h0000_0000, rx_irq}, 32'h0000_0001);
    apb(asp2_pkg::RX_HOLDING_ADDR, 1'b0, 8'h00);
    chk("rx_holding", rd, 32'(v[7:0] & (len == 7 ? 8'h7f : 8'hff)));
    apb(asp2_pkg::RX_CONTROL_ADDR, 1'b0, 8'h00);
    chk("rx_control", rd, 32'(8'h43 | (stop ? 8'h00 : 8'h10) | (len == 9 && v[8] ? 8'h04 : 8'h00)));
    apb(asp2_pkg::RX_CONTROL_ADDR, 1'b1, 8'h41);
  endtask

  initial begin : main
    logic [8:0] d2;
    int t0;
    {psel, penable, pwrite, port_dir_tx, oe_bad, pd_q} = 6'h00;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
    rst_n = 1'b0;
    void'($urandom(57685));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, an unmapped word, and read-back of stored fields.
    foreach (addrs[i]) begin
      apb(addrs[i], 1'b0, 8'h00);
      chk("reset value", rd, 32'h0000_0000);
    end
    apb(18'h3_fbb4, 1'b0, 8'h00);
    chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
    for (int i = 2; i < 5; i++) begin
      d = 9'($urandom);
      apb(addrs[i], 1'b1, d[7:0]);
      apb(addrs[i], 1'b0, 8'h00);
      chk("read back", rd, 32'(d[7:0]));
    end
    apb(asp2_pkg::RX_CONTROL_ADDR, 1'b1, 8'h08);
    apb(asp2_pkg::RX_CONTROL_ADDR, 1'b0, 8'h00);
    chk("general flag", rd, 32'h0000_0008);
    // Every length at the fine range, then length 8 at the coarse range.
    apb(asp2_pkg::BAUD_RELOAD_ADDR, 1'b1, 8'h02);
    foreach (lens[i]) tx_one(lens[i], 9'($urandom));
    apb(asp2_pkg::RX_CONTROL_ADDR, 1'b1, 8'h80);
    u_peer.bit_cyc = 32;
    tx_one(8, 9'($urandom));
    // The range bit is shared with reception, so it goes back to fine before the later tests.
    apb(asp2_pkg::RX_CONTROL_ADDR, 1'b1, 8'h00);
    u_peer.bit_cyc = 8;
    // The direction bit keeps the pin quiet for a whole character.
    port_dir_tx <= 1'b1;
    apb(asp2_pkg::TX_CONTROL_ADDR, 1'b1, 8'hb1);
    wait_bit(asp2_pkg::TX_CONTROL_ADDR, asp2_pkg::TC_RUN, 1'b0);
    chk("suppressed frames", u_peer.got_q.size(), 32'h0000_0000);
    chk("pin enable", {31'h0000_0000, oe_bad}, 32'h0000_0000);
    port_dir_tx <= 1'b0;
    // Continuous transmit in open-drain type; a rate change after the start must not take effect.
    u_peer.start_t.delete();
    d = 9'($urandom) & 9'h0ff;
    d2 = 9'($urandom) & 9'h0ff;
    apb(asp2_pkg::TX_HOLDING_ADDR, 1'b1, d[7:0]);
    apb(asp2_pkg::TX_CONTROL_ADDR, 1'b1, 8'ha1);
    apb(asp2_pkg::TX_HOLDING_ADDR, 1'b1, d2[7:0]);
    apb(asp2_pkg::BAUD_RELOAD_ADDR, 1'b1, 8'h05);
    apb(asp2_pkg::TX_CONTROL_ADDR, 1'b1, 8'ha1);
    get_frame(8, d);
    get_frame(8, d2);
    t0 = u_peer.start_t.size() > 1 ? u_peer.start_t[1] - u_peer.start_t[0] : 0;
    chk("char spacing", 32'(t0 >= 88 && t0 <= 90), 32'h0000_0001);
    wait_bit(asp2_pkg::TX_CONTROL_ADDR, asp2_pkg::TC_RUN, 1'b0);
    apb(asp2_pkg::BAUD_RELOAD_ADDR, 1'b1, 8'h02);
    // Reception with the length changed between characters, then a bad stop bit.
    // receive pin input
    // The peer alone drives the receive pin, as if its direction bit were cleared.
    apb(asp2_pkg::RX_CONTROL_ADDR, 1'b1, 8'h41);
    for (int i = 0; i < 4; i++) begin
      apb(asp2_pkg::TX_CONTROL_ADDR, 1'b1, lens[i%3] == 9 ? 8'h40 : (lens[i%3] == 7 ? 8'h08 : 8'h00));
      d = 9'($urandom);
      u_peer.send_char(d, lens[i%3], 8, i < 3);
      rx_check(lens[i%3], d, i < 3);
    end
    // Both directions at once.
    d = 9'($urandom) & 9'h0ff;
    d2 = 9'($urandom) & 9'h0ff;
    // The receiver latches its length at the start edge, before tx_one writes its own control.
    apb(asp2_pkg::TX_CONTROL_ADDR, 1'b1, 8'h00);
    fork
      tx_one(8, d);
      u_peer.send_char(d2, 8, 8, 1'b1);
    join
    rx_check(8, d2, 1'b1);
    wrap_up();
  end
endmodule // tb
